/* core/drop_alarm_pkg.sv */
// Constants, register map and reset values for the drop alarm status and leak-rate bank.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
package drop_alarm_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned CLK_LOSS_NS     = 1000;
  // Longest time, so rounded down; still inside the 500 ns tolerance
  localparam int unsigned CLK_LOSS_CYC    = CLK_LOSS_NS / CLK_PERIOD_NS;
  localparam int unsigned FRAMES_PER_UNIT = 8;
  localparam int unsigned MF_GOOD_NEEDED  = 4;

  // ---------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_ALARM_LATCHED = 8'h28;
  localparam logic [7:0] IDX_ALARM_STATUS  = 8'h29;
  localparam logic [7:0] IDX_LEAK_PORT1    = 8'h49;
  localparam logic [7:0] IDX_LEAK_PORT2    = 8'h79;
  localparam logic [7:0] IDX_LEAK_PORT3    = 8'ha9;
  localparam logic [7:0] IDX_LEAK_PORT4    = 8'hd9;
  localparam logic [7:0] IDX_ALARM_CLEAR   = 8'he0;
  localparam logic [7:0] IDX_ALARM_ENABLE  = 8'he1;
  localparam logic [7:0] IDX_CONTROL       = 8'he2;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned BIT_CLK_LOSS   = 7;
  localparam int unsigned BIT_WATCHDOG   = 6;
  localparam int unsigned BIT_PARITY     = 4;
  localparam int unsigned BIT_SRC_SELECT = 0;
  localparam int unsigned BIT_SINGLE_FMT = 1;

  // ---------------------------------------------------------------
  // Reset values and responses
  // ---------------------------------------------------------------
  localparam logic [2:0] MF_LOSS_RESET = 3'h6;
  localparam logic [7:0] LEAK_RESET    = 8'h00;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage

/* core/drop_alarm_status_leak_rate.sv */
// Alarm status bank, latched alarms with interrupt, H4 multiframe checkers and four pointer leak-rate ports.
// Assumes all inputs are synchronous to clk_sys_in and an AXI4-Lite master on the register bus.
//
// Behaviour
// (R1) Processor clock is the reference clock halved and is watched for loss.
// (R2) Loss flag sets when the derived clock is stuck for about 1000 ns.
// (R3) Loss flag clears on the first transition of the derived clock.
// (R4) Watchdog flag sets when the processor misses its service deadline.
// (R5) Status bits 5 and 3 always read as zero.
// (R6) Parity flag sets on an instruction memory fetch parity mismatch.
// (R7) With source select 0, two bad multiframes in a row declare H4 loss.
// (R8) Expected H4 phase runs 00, 01, 10, 11, one step per frame.
// (R9) Counter stays free running in loss; one good multiframe realigns it.
// (R10) Channels two and three checkers are off for single-channel formats.
// (R11) Channels two and three loss flags come up set at reset.
// (R12) Software writes an 8-bit leak count per port, used as leak rate.
// (R13) One count unit is 8 frames between leaked pointer adjustments.
// (R14) Leak direction and amount come from positive and negative stuff counts.
// (R15) Register below status mirrors its bits as latched indications.
// (R16) Latched bits stay set until software writes one to clear them.
// (R17) Four independent leak-rate registers, one per port.
`timescale 1ns/100ps
`default_nettype none

module drop_alarm_status_leak_rate (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        arst_n_in,
  // Processor side
  input  wire logic        desync_reference_clock_in,
  input  wire logic        watchdog_expiry_in,
  input  wire logic        instr_mem_parity_in,
  // Drop bus H4 per channel
  input  wire logic [2:0]  h4_frame_in,
  input  wire logic [5:0]  h4_value_in,
  // Desynchronizer per port, processor clock and interrupt
  input  wire logic        frame_tick_in,
  input  wire logic [3:0]  pos_stuff_in,
  input  wire logic [3:0]  neg_stuff_in,
  output logic      [3:0]  leak_pos_out,
  output logic      [3:0]  leak_neg_out,
  output logic             processor_clock_out,
  output logic             irq_out,
  // AXI4-Lite write
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_sync1_reg;
  logic rst_n_reg;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync1_reg <= 1'b0;
      rst_n_reg     <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_n_reg     <= rst_sync1_reg;
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                  ref_q;
    logic                  div_clk;
    logic                  div_prev;
    logic [5:0]            stuck_cnt;
    logic                  clk_loss;
    logic                  wd_live;
    logic                  par_live;
    logic [2:0][1:0]       mf_cnt;
    logic [2:0]            mf_err;
    logic [2:0]            mf_miss;
    logic [2:0]            mf_loss;
    logic [2:0][1:0]       h4_prev;
    logic [2:0][2:0]       h4_good;
    logic [7:0]            stat_prev;
    logic [7:0]            latched;
    logic [7:0]            enable;
    logic [1:0]            ctrl;
    logic [3:0][7:0]       leak_rate;
    logic [3:0][10:0]      leak_frm;
    logic [3:0][7:0]       net;
    logic [3:0]            leak_pos;
    logic [3:0]            leak_neg;
    logic                  irq;
    logic                  aw_hold;
    logic [7:0]            aw_idx;
    logic                  w_hold;
    logic [7:0]            w_byte;
    logic                  w_lane0;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic [7:0] status_w;
  logic [7:0] clear_w;

  localparam logic [5:0] LOSS_LIMIT = 6'(drop_alarm_pkg::CLK_LOSS_CYC);
  localparam logic [2:0] GOOD_LAST  = 3'(drop_alarm_pkg::MF_GOOD_NEEDED - 1);

  always_comb begin
    logic       wr_fire;
    logic [7:0] ridx;
    logic [1:0] v;
    logic       en;
    logic       mism;
    logic       err_acc;
    logic [2:0] good;
    logic       single_fmt;
    st_next    = st_reg;
    wr_fire    = 1'b0;
    ridx       = 8'h00;
    v          = 2'h0;
    en         = 1'b0;
    mism       = 1'b0;
    err_acc    = 1'b0;
    good       = 3'h0;
    single_fmt = st_reg.ctrl[drop_alarm_pkg::BIT_SINGLE_FMT];
    clear_w    = 8'h00;

    // -------------------------------------------------------------
    // Processor clock derivation and loss monitor
    // -------------------------------------------------------------
    st_next.ref_q    = desync_reference_clock_in;
    if (desync_reference_clock_in && !st_reg.ref_q) begin
      st_next.div_clk = ~st_reg.div_clk;                           // R1
    end
    st_next.div_prev = st_reg.div_clk;
    if (st_reg.div_clk != st_reg.div_prev) begin
      st_next.stuck_cnt = 6'h00;
      st_next.clk_loss  = 1'b0;                                    // R3
    end else if (st_reg.stuck_cnt == LOSS_LIMIT - 6'h01) begin
      st_next.clk_loss  = 1'b1;                                    // R2
    end else begin
      st_next.stuck_cnt = st_reg.stuck_cnt + 6'h01;
    end
    st_next.wd_live  = watchdog_expiry_in;                         // R4
    st_next.par_live = instr_mem_parity_in;                        // R6

    // -------------------------------------------------------------
    // H4 multiframe checkers
    // -------------------------------------------------------------
    for (int c = 0; c < 3; c++) begin
      if (h4_frame_in[c]) begin
        v  = h4_value_in[2*c +: 2];
        en = !st_reg.ctrl[drop_alarm_pkg::BIT_SRC_SELECT] && !(c > 0 && single_fmt); // R7 R10
        st_next.mf_cnt[c] = st_reg.mf_cnt[c] + 2'h1;               // R8
        if (en) begin
          mism    = (v != st_reg.mf_cnt[c]);
          err_acc = st_reg.mf_err[c] | mism;
          if (st_reg.mf_cnt[c] == 2'h3) begin
            st_next.mf_err[c] = 1'b0;
            if (err_acc && st_reg.mf_miss[c]) begin
              st_next.mf_loss[c] = 1'b1;                           // R7
            end
            st_next.mf_miss[c] = err_acc;
          end else begin
            st_next.mf_err[c] = err_acc;
          end
          good = (v == st_reg.h4_prev[c] + 2'h1) ? st_reg.h4_good[c] + 3'h1 : 3'h1;
          if (good > GOOD_LAST + 3'h1) begin
            good = GOOD_LAST + 3'h1;
          end
          st_next.h4_good[c] = good;
          st_next.h4_prev[c] = v;
          if (st_reg.mf_loss[c] && good > GOOD_LAST) begin
            st_next.mf_loss[c] = 1'b0;                             // R9
            st_next.mf_cnt[c]  = v + 2'h1;                         // R9
            st_next.mf_err[c]  = 1'b0;
            st_next.mf_miss[c] = 1'b0;
          end
        end
      end
    end

    // -------------------------------------------------------------
    // Leak-rate ports
    // -------------------------------------------------------------
    for (int p = 0; p < 4; p++) begin
      st_next.leak_pos[p] = 1'b0;
      st_next.leak_neg[p] = 1'b0;
      if (pos_stuff_in[p] && !neg_stuff_in[p] && st_reg.net[p] != 8'h7f) begin
        st_next.net[p] = st_reg.net[p] + 8'h01;                    // R14
      end else if (neg_stuff_in[p] && !pos_stuff_in[p] && st_reg.net[p] != 8'h80) begin
        st_next.net[p] = st_reg.net[p] - 8'h01;                    // R14
      end
      // Rate zero stops leaking altogether
      if (frame_tick_in && st_reg.leak_rate[p] != 8'h00) begin
        if (st_reg.leak_frm[p] <= 11'h001) begin
          st_next.leak_frm[p] = {st_reg.leak_rate[p], 3'h0};       // R13
          if (!st_next.net[p][7] && st_next.net[p] != 8'h00) begin
            st_next.leak_pos[p] = 1'b1;                            // R12
            st_next.net[p]      = st_next.net[p] - 8'h01;
          end else if (st_next.net[p][7]) begin
            st_next.leak_neg[p] = 1'b1;                            // R12
            st_next.net[p]      = st_next.net[p] + 8'h01;
          end
        end else begin
          st_next.leak_frm[p] = st_reg.leak_frm[p] - 11'h001;
        end
      end
    end

    // -------------------------------------------------------------
    // AXI4-Lite write
    // -------------------------------------------------------------
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_hold = 1'b1;
      st_next.aw_idx  = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_hold  = 1'b1;
      st_next.w_byte  = s_axi_wdata[7:0];
      st_next.w_lane0 = s_axi_wstrb[0];
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid) begin
      wr_fire         = 1'b1;
      st_next.aw_hold = 1'b0;
      st_next.w_hold  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = drop_alarm_pkg::RESP_OKAY;
    end
    if (wr_fire) begin
      if (st_reg.aw_idx == drop_alarm_pkg::IDX_LEAK_PORT1) begin
        if (st_reg.w_lane0) st_next.leak_rate[0] = st_reg.w_byte;  // R17
      end else if (st_reg.aw_idx == drop_alarm_pkg::IDX_LEAK_PORT2) begin
        if (st_reg.w_lane0) st_next.leak_rate[1] = st_reg.w_byte;  // R17
      end else if (st_reg.aw_idx == drop_alarm_pkg::IDX_LEAK_PORT3) begin
        if (st_reg.w_lane0) st_next.leak_rate[2] = st_reg.w_byte;  // R17
      end else if (st_reg.aw_idx == drop_alarm_pkg::IDX_LEAK_PORT4) begin
        if (st_reg.w_lane0) st_next.leak_rate[3] = st_reg.w_byte;  // R17
      end else if (st_reg.aw_idx == drop_alarm_pkg::IDX_ALARM_CLEAR) begin
        if (st_reg.w_lane0) clear_w = st_reg.w_byte;               // R16
      end else if (st_reg.aw_idx == drop_alarm_pkg::IDX_ALARM_ENABLE) begin
        if (st_reg.w_lane0) st_next.enable = st_reg.w_byte;
      end else if (st_reg.aw_idx == drop_alarm_pkg::IDX_CONTROL) begin
        if (st_reg.w_lane0) st_next.ctrl = st_reg.w_byte[1:0];
      end else if (st_reg.aw_idx != drop_alarm_pkg::IDX_ALARM_STATUS &&
                   st_reg.aw_idx != drop_alarm_pkg::IDX_ALARM_LATCHED) begin
        st_next.bresp = drop_alarm_pkg::RESP_SLVERR;
      end
    end
    // Address and data are each taken once, then held until the write is done
    st_next.awready = !st_next.aw_hold && !st_next.bvalid;
    st_next.wready  = !st_next.w_hold && !st_next.bvalid;

    // -------------------------------------------------------------
    // Latched alarms and interrupt; a new event wins over a clear
    // -------------------------------------------------------------
    st_next.stat_prev = status_w;
    st_next.latched   = (st_reg.latched & ~clear_w) | (status_w & ~st_reg.stat_prev); // R15 R16
    st_next.irq       = |(st_next.latched & st_next.enable);

    // -------------------------------------------------------------
    // AXI4-Lite read
    // -------------------------------------------------------------
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      ridx          = s_axi_araddr[9:2];
      st_next.rvalid = 1'b1;
      st_next.rresp  = drop_alarm_pkg::RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      if (ridx == drop_alarm_pkg::IDX_ALARM_STATUS) begin
        st_next.rdata[7:0] = status_w;
      end else if (ridx == drop_alarm_pkg::IDX_ALARM_LATCHED) begin
        st_next.rdata[7:0] = st_reg.latched;
      end else if (ridx == drop_alarm_pkg::IDX_LEAK_PORT1) begin
        st_next.rdata[7:0] = st_reg.leak_rate[0];
      end else if (ridx == drop_alarm_pkg::IDX_LEAK_PORT2) begin
        st_next.rdata[7:0] = st_reg.leak_rate[1];
      end else if (ridx == drop_alarm_pkg::IDX_LEAK_PORT3) begin
        st_next.rdata[7:0] = st_reg.leak_rate[2];
      end else if (ridx == drop_alarm_pkg::IDX_LEAK_PORT4) begin
        st_next.rdata[7:0] = st_reg.leak_rate[3];
      end else if (ridx == drop_alarm_pkg::IDX_ALARM_ENABLE) begin
        st_next.rdata[7:0] = st_reg.enable;
      end else if (ridx == drop_alarm_pkg::IDX_CONTROL) begin
        st_next.rdata[1:0] = st_reg.ctrl;
      end else if (ridx != drop_alarm_pkg::IDX_ALARM_CLEAR) begin
        st_next.rresp = drop_alarm_pkg::RESP_SLVERR;
      end
    end
    st_next.arready = !st_next.rvalid;
  end

  // Live status word; unused positions are tied low
  always_comb begin
    status_w = 8'h00;                                              // R5
    status_w[drop_alarm_pkg::BIT_CLK_LOSS] = st_reg.clk_loss;
    status_w[drop_alarm_pkg::BIT_WATCHDOG] = st_reg.wd_live;
    status_w[drop_alarm_pkg::BIT_PARITY]   = st_reg.par_live;
    status_w[2:0]                          = st_reg.mf_loss;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      st_reg           <= '0;
      st_reg.mf_loss   <= drop_alarm_pkg::MF_LOSS_RESET;          // R11
      st_reg.stat_prev <= {5'h00, drop_alarm_pkg::MF_LOSS_RESET};
      st_reg.latched   <= {5'h00, drop_alarm_pkg::MF_LOSS_RESET};
      st_reg.leak_rate <= {4{drop_alarm_pkg::LEAK_RESET}};
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign leak_pos_out        = st_reg.leak_pos;
  assign leak_neg_out        = st_reg.leak_neg;
  assign processor_clock_out = st_reg.div_clk;
  assign irq_out             = st_reg.irq;
  assign s_axi_awready       = st_reg.awready;
  assign s_axi_wready        = st_reg.wready;
  assign s_axi_bvalid        = st_reg.bvalid;
  assign s_axi_bresp         = st_reg.bresp;
  assign s_axi_arready       = st_reg.arready;
  assign s_axi_rvalid        = st_reg.rvalid;
  assign s_axi_rdata         = st_reg.rdata;
  assign s_axi_rresp         = st_reg.rresp;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_reg);

  sequence ref_rise_s;
    desync_reference_clock_in && !st_reg.ref_q;
  endsequence

  sequence bad_mf_s;
    h4_frame_in[0] && st_reg.mf_cnt[0] == 2'h3 && st_reg.mf_miss[0] && !st_reg.mf_loss[0];
  endsequence

  clk_half_a: assert property (ref_rise_s |=> st_reg.div_clk != $past(st_reg.div_clk)) // R1
    else $error("Processor clock did not toggle on reference edge");
  clk_loss_set_a: assert property ($rose(st_reg.clk_loss) |-> $past(st_reg.stuck_cnt) == LOSS_LIMIT - 6'h01) // R2
    else $error("Clock loss raised at wrong count");
  clk_loss_clear_a: assert property (st_reg.clk_loss && st_reg.div_clk != st_reg.div_prev |=> !st_reg.clk_loss) // R3
    else $error("Clock loss not cleared on transition");
  wd_latch_a: assert property ($rose(st_reg.wd_live) |=> st_reg.latched[drop_alarm_pkg::BIT_WATCHDOG] ##1 irq_out || !st_reg.enable[drop_alarm_pkg::BIT_WATCHDOG]) // R4
    else $error("Watchdog event not latched");
  unused_zero_a: assert property (s_axi_rvalid && $past(s_axi_araddr[9:2]) == drop_alarm_pkg::IDX_ALARM_STATUS && $rose(s_axi_rvalid) |-> s_axi_rdata[5] == 1'b0 && s_axi_rdata[3] == 1'b0) // R5
    else $error("Unused status bits read nonzero");
  parity_latch_a: assert property ($rose(st_reg.par_live) |=> st_reg.latched[drop_alarm_pkg::BIT_PARITY]) // R6
    else $error("Parity event not latched");
  h4_loss_a: assert property (bad_mf_s ##0 (st_reg.mf_err[0] || h4_value_in[1:0] != 2'h3) ##0 !st_reg.ctrl[0] |=> st_reg.mf_loss[0]) // R7
    else $error("H4 loss not declared after two bad multiframes");
  h4_rise_a: assert property ($rose(st_reg.mf_loss[0]) |-> $past(st_reg.mf_miss[0]) && $past(h4_frame_in[0])) // R7
    else $error("H4 loss raised without a prior bad multiframe");
  h4_disable_a: assert property (st_reg.ctrl[drop_alarm_pkg::BIT_SINGLE_FMT] |=> $stable(st_reg.mf_loss[2:1])) // R10
    else $error("Disabled H4 checker changed its flag");
  latch_hold_a: assert property (st_reg.latched[0] && clear_w[0] == 1'b0 |=> st_reg.latched[0]) // R16
    else $error("Latched bit dropped without a clear");
  leak_gap_a: assert property (leak_pos_out[0] |-> $past(frame_tick_in) ##1 !leak_pos_out[0] [*1]) // R13
    else $error("Leak pulse not tied to a frame tick");

endmodule

`default_nettype wire

/* sim/drop_bus_model.sv */
// Behavioural drop bus source: H4 phase per channel and the frame tick.
// Assumes the bench runs it on the system clock; one frame every four clocks.
`timescale 1ns/100ps
`default_nettype none

module drop_bus_model (
  // Clock and control
  input  wire logic       clk_sys_in,
  input  wire logic       run_in,
  input  wire logic [2:0] bad_in,
  // Drop bus
  output logic      [2:0] h4_frame_out,
  output logic      [5:0] h4_value_out,
  output logic            frame_tick_out
);
  logic [1:0] gap_reg   = 2'h0;
  logic [1:0] phase_reg = 2'h0;

  initial h4_frame_out = 3'h0;
  initial h4_value_out = 6'h00;
  initial frame_tick_out = 1'b0;

  always @(posedge clk_sys_in) begin
    h4_frame_out <= 3'h0;
    frame_tick_out <= 1'b0;
    // Between frames the H4 lines carry no phase, so they keep changing
    h4_value_out <= ~h4_value_out;
    if (run_in) begin
      gap_reg <= gap_reg + 2'h1;
    end
    if (run_in && gap_reg == 2'h3) begin
      phase_reg <= phase_reg + 2'h1;
      h4_frame_out <= 3'h7;
      frame_tick_out <= 1'b1;
      for (int c = 0; c < 3; c++) begin
        h4_value_out[2*c+:2] <= bad_in[c] ? ~phase_reg : phase_reg;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the drop alarm status and leak-rate bank.
// Assumes drop_bus_model feeds the H4 and frame inputs; bus tasks start after an edge.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; $display("MISMATCH %0t got %h exp %h", $time, a, e); end end

module tb_top;
  localparam logic [7:0] ST = drop_alarm_pkg::IDX_ALARM_STATUS;
  localparam logic [7:0] LA = drop_alarm_pkg::IDX_ALARM_LATCHED;
  localparam logic [7:0] CL = drop_alarm_pkg::IDX_ALARM_CLEAR;
  localparam logic [7:0] EN = drop_alarm_pkg::IDX_ALARM_ENABLE;
  localparam logic [7:0] CT = drop_alarm_pkg::IDX_CONTROL;
  localparam logic [1:0] OK = drop_alarm_pkg::RESP_OKAY;
  localparam logic [1:0] ER = drop_alarm_pkg::RESP_SLVERR;
  logic clk = 1'b0, rst_n = 1'b0, refc = 1'b0, ref_run = 1'b1, wdog = 1'b0, par = 1'b0, run = 1'b0, stuff = 1'b0;
  logic [2:0] bad = 3'h0, h4f;
  logic [5:0] h4v;
  logic ft, pclk, pc_d, irq, awv = 1'b0, awr, wv = 1'b0, wrdy, bv, bry = 1'b0, arv = 1'b0, arr, rv, rry = 1'b0;
  logic [3:0] pst = 4'h0, nst = 4'h0, lp, ln;
  logic [31:0] aw = 32'h0, wd = 32'h0, ar = 32'h0, rdat;
  logic [1:0] br, rr;
  int err_count = 0, n_checks = 0;
  int lk [4];

  drop_bus_model far_u (.clk_sys_in(clk), .run_in(run), .bad_in(bad), .h4_frame_out(h4f), .h4_value_out(h4v),
    .frame_tick_out(ft));
  drop_alarm_status_leak_rate dut_u (.clk_sys_in(clk), .arst_n_in(rst_n), .desync_reference_clock_in(refc),
    .watchdog_expiry_in(wdog), .instr_mem_parity_in(par), .h4_frame_in(h4f), .h4_value_in(h4v),
    .frame_tick_in(ft), .pos_stuff_in(pst), .neg_stuff_in(nst), .leak_pos_out(lp), .leak_neg_out(ln),
    .processor_clock_out(pclk), .irq_out(irq), .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (ref_run) refc <= ~refc;
    pc_d <= pclk;
    // Steady stuffing keeps the net count away from zero
    pst <= {3'h0, stuff & ft};
    nst <= {2'h0, stuff & ft, 1'b0};
  end

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic wchk(input logic [7:0] i, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    aw <= {22'h0, i, 2'h0}; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    bry <= 1'b0;
    `CHK(br, e)
  endtask

  task automatic rchk(input logic [7:0] i, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    ar <= {22'h0, i, 2'h0}; arv <= 1'b1; rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rry <= 1'b0;
    `CHK(rr, er)
    `CHK(rdat, e)
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #400_000;
    err_count++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin : main
    logic [7:0] li [4];
    int rt, t0, n, m, q;
    li = '{drop_alarm_pkg::IDX_LEAK_PORT1, drop_alarm_pkg::IDX_LEAK_PORT2, drop_alarm_pkg::IDX_LEAK_PORT3,
      drop_alarm_pkg::IDX_LEAK_PORT4};
    void'($urandom(71));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(ST, 32'h06, OK);
    rchk(LA, 32'h06, OK);
    for (int p = 0; p < 4; p++) rchk(li[p], 32'h0, OK);
    for (int p = 0; p < 4; p++) begin
      lk[p] = 1 + $urandom % 255;
      wchk(li[p], ($urandom & 32'hffff_ff00) | 32'(lk[p]), OK);
    end
    for (int p = 0; p < 4; p++) rchk(li[p], 32'(lk[p]), OK);
    wchk(8'h10, 32'h0000_00ff, ER);
    rchk(8'h10, 32'h0, ER);
    wchk(ST, 32'h0000_00ff, OK);
    rchk(CL, 32'h0, OK);
    run <= 1'b1;
    repeat (100) @(posedge clk);
    rchk(ST, 32'h0, OK);
    bad <= 3'h1; repeat (60) @(posedge clk);
    rchk(ST, 32'h01, OK);
    bad <= 3'h0; repeat (60) @(posedge clk);
    rchk(ST, 32'h0, OK);
    wchk(CT, 32'h02, OK); bad <= 3'h6; repeat (60) @(posedge clk);
    rchk(ST, 32'h0, OK);
    wchk(CT, 32'h01, OK); bad <= 3'h1; repeat (60) @(posedge clk);
    rchk(ST, 32'h0, OK);
    wchk(CT, 32'h0, OK); bad <= 3'h0; repeat (120) @(posedge clk);
    rchk(ST, 32'h0, OK);
    wchk(CL, 32'h0000_00ff, OK);
    rchk(LA, 32'h0, OK);
    wchk(EN, 32'h10, OK);
    wdog <= 1'b1; repeat (4) @(posedge clk);
    `CHK(irq, 1'b0)
    par <= 1'b1; repeat (4) @(posedge clk);
    `CHK(irq, 1'b1)
    rchk(ST, 32'h50, OK);
    wdog <= 1'b0; par <= 1'b0; repeat (4) @(posedge clk);
    rchk(ST, 32'h0, OK);
    rchk(LA, 32'h50, OK);
    wchk(CL, 32'h40, OK);
    rchk(LA, 32'h10, OK);
    wchk(CL, 32'h10, OK); repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    n = 0;
    repeat (40) begin @(posedge clk); n += int'(pclk !== pc_d); end
    `CHK(n, 20)
    ref_run <= 1'b0; repeat (18) @(posedge clk);
    rchk(ST, 32'h0, OK);
    repeat (50) @(posedge clk);
    rchk(ST, 32'h80, OK);
    ref_run <= 1'b1; repeat (8) @(posedge clk);
    rchk(ST, 32'h0, OK);
    rt = 1 + $urandom % 3;
    wchk(li[0], 32'(rt), OK); wchk(li[1], 32'(rt), OK);
    stuff <= 1'b1; n = 0; t0 = 0; m = 0; q = 0;
    // First pulse may wait out the count left from the earlier random rate
    for (int c = 0; c < 9000 && (n < 3 || m == 0); c++) begin
      @(posedge clk);
      m += int'(ln[1] === 1'b1); q += int'((lp[1] | ln[0]) !== 1'b0);
      if (lp[0] === 1'b1 && n < 3) begin
        if (n == 2) `CHK(c - t0, rt * 32)
        n++; t0 = c;
      end
    end
    `CHK(m > 0 && q == 0 && n == 3, 1'b1)
    complete_run();
  end
endmodule
`default_nettype wire
